// *** tb_vme_interrupt_handler_bridge.sv ***
// Self-checking testbench for the VME interrupt handler bridge
`default_nettype none

`include "vihb_defs.svh"

module tb_vme_interrupt_handler_bridge
	import vihb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:1] irq_n;
	logic dtack_n;
	logic [7:0] vme_data;
	vihb_vme_out_type vme;
	logic bus_req;
	logic bus_grant;
	vihb_cmd_type irq_cmd;
	vihb_cmd_type err_cmd;
	logic ident_valid = 1'b0;
	logic vec_valid;
	logic [15:0] vec;
	logic [5:0] err_event = 6'h00;
	logic err_write = 1'b0;
	logic [31:0] err_info = 32'h0;
	logic [7:1] raise = 7'h00;
	logic [3:0] grant_dly = 4'h0;
	int miscompares = 0;
	int check_count = 0;
	logic [31:0] rd;

	always #50 clk_i = ~clk_i;

	vihb_core vihb_core_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address),
		.avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
		.irq_n_i(irq_n), .dtack_n_i(dtack_n), .berr_n_i(1'b1), .vme_data_i(vme_data), .vme_o(vme),
		.bus_req_o(bus_req), .bus_grant_i(bus_grant), .irq_cmd_o(irq_cmd), .err_cmd_o(err_cmd),
		.ident_valid_i(ident_valid), .vec_valid_o(vec_valid), .vec_o(vec), .err_event_i(err_event),
		.err_write_i(err_write), .err_info_i(err_info));

	vihb_vme_model vihb_vme_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .vme_i(vme),
		.bus_req_i(bus_req), .raise_i(raise), .grant_dly_i(grant_dly), .irq_n_o(irq_n),
		.dtack_n_o(dtack_n), .data_o(vme_data), .bus_grant_o(bus_grant));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : compare

	task automatic give_up;
		miscompares++;
		$display("wrong value at %0t: no answer in time", $time);
		report_and_stop();
	endtask : give_up

	// Avalon-MM access; the request stands until waitrequest is sampled low
	task automatic bus_xfer(input logic wr, input logic [2:0] a, input logic [31:0] wd);
		int i;
		@(posedge clk_i);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk_i);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (i == 50)
			give_up();
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus_xfer

	task automatic wait_for(input int which);
		int i;
		for (i = 0; i < 300; i++)
		begin
			@(negedge clk_i);
			if ((which == 0 ? irq_cmd.valid : vec_valid) === 1'b1)
				break;
		end
		if (i == 300)
			give_up();
	endtask : wait_for

	task automatic pulse_raise(input logic [7:1] m);
		@(posedge clk_i);
		raise <= m;
		@(posedge clk_i);
		raise <= 7'h00;
	endtask : pulse_raise

	// One full service: command, identify, acknowledge, vector
	task automatic serve(input logic [2:0] lvl, input logic [1:0] hl, input logic [10:0] other);
		wait_for(0);
		compare(irq_cmd.level, hl);
		compare(irq_cmd.implied, 1'b0);
		bus_xfer(1'b0, `VIHB_ESR_IDX, 32'h0);
		compare(rd[10:0], other | (11'h1 << (3 + lvl)) | (11'h1 << hl));
		@(posedge clk_i);
		ident_valid <= 1'b1;
		@(posedge clk_i);
		ident_valid <= 1'b0;
		wait_for(1);
		compare(vec, {8'hab, lvl, 5'h14});
		bus_xfer(1'b0, `VIHB_ESR_IDX, 32'h0);
		compare(rd[10:4], other[10:4]);
		if (other == 11'h0)
			compare(rd[3:0], 4'h0);
	endtask : serve

	task automatic err_pulse(input int n, input logic wr, input logic [31:0] info, input logic en);
		@(posedge clk_i);
		err_event <= 6'h01 << n;
		err_write <= wr;
		err_info <= info;
		@(posedge clk_i);
		err_event <= 6'h00;
		@(negedge clk_i);
		compare(err_cmd.valid, en);
		if (en)
		begin
			compare(err_cmd.implied, wr);
			compare(err_cmd.level, 2'h1);
		end
	endtask : err_pulse

	// A host command may only leave once the VMEbus is ours
	always @(negedge clk_i)
		if (irq_cmd.valid === 1'b1)
			compare(bus_grant, 1'b1);

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		int n;
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		bus_xfer(1'b0, `VIHB_ICR_IDX, 32'h0);
		compare(rd, 32'h0e000fac);
		bus_xfer(1'b0, `VIHB_DCR_IDX, 32'h0);
		compare(rd, 32'h00003000);
		bus_xfer(1'b1, 3'h5, 32'hffffffff);
		bus_xfer(1'b0, 3'h5, 32'h0);
		compare(rd, 32'h0);
		bus_xfer(1'b1, `VIHB_VOR_IDX, 32'hffffabff);
		bus_xfer(1'b0, `VIHB_VOR_IDX, 32'h0);
		compare(rd, 32'h0000ab00);
		$display("test registers done");
		pulse_raise(7'h40);
		serve(3'h7, 2'h3, 11'h000);
		grant_dly <= 4'h8;
		pulse_raise(7'h30);
		serve(3'h6, 2'h2, 11'h100);
		serve(3'h5, 2'h1, 11'h000);
		$display("test service and priority done");
		// Level 2 is disabled by default and must only pend
		pulse_raise(7'h02);
		n = 0;
		repeat (40)
		begin
			@(negedge clk_i);
			if (irq_cmd.valid === 1'b1)
				n++;
		end
		compare(n, 0);
		bus_xfer(1'b0, `VIHB_ESR_IDX, 32'h0);
		compare(rd[10:4], 7'h02);
		bus_xfer(1'b1, `VIHB_ICR_IDX, 32'h8a000faa);
		pulse_raise(7'h40);
		serve(3'h2, 2'h0, 11'h400);
		bus_xfer(1'b1, `VIHB_ICR_IDX, 32'h0e000fac);
		serve(3'h7, 2'h3, 11'h000);
		$display("test mapping and masking done");
		err_pulse(0, 1'b0, 32'h0000a5a5, 1'b0);
		bus_xfer(1'b0, `VIHB_ESR_IDX, 32'h0);
		compare(rd[20:14], 7'h02);
		bus_xfer(1'b1, `VIHB_ESR_IDX, 32'h001fc000);
		bus_xfer(1'b1, `VIHB_DCR_IDX, 32'h00011040);
		bus_xfer(1'b0, `VIHB_DCR_IDX, 32'h0);
		compare(rd, 32'h00011040);
		for (int k = 0; k < 6; k++)
			err_pulse(k, k[0], 32'h100 + k, 1'b1);
		bus_xfer(1'b0, `VIHB_ESR_IDX, 32'h0);
		compare(rd[20:14], 7'h7f);
		bus_xfer(1'b0, `VIHB_EDR_IDX, 32'h0);
		compare(rd, 32'h00000100);
		bus_xfer(1'b1, `VIHB_ESR_IDX, 32'h001fc000);
		err_pulse(2, 1'b0, 32'h00000077, 1'b1);
		bus_xfer(1'b0, `VIHB_EDR_IDX, 32'h0);
		compare(rd, 32'h00000077);
		$display("test errors done");
		// Level 7 now releases on register access, so only its edge pends
		pulse_raise(7'h40);
		serve(3'h7, 2'h3, 11'h000);
		$display("test release types done");
		report_and_stop();
	end

endmodule : tb_vme_interrupt_handler_bridge

`default_nettype wire

// *** vihb_core.sv ***
// VME interrupt handler bridge: IRQ capture, acknowledge cycles, host commands, error logging
`default_nettype none

`include "vihb_defs.svh"

module vihb_core
	import vihb_pkg::*;
#(
	parameter int unsigned ERR_N = 6 // Number of error sources in use
)(
	input wire logic clk_i, // 10 MHz module clock
	input wire logic arst_n_i, // Asynchronous reset, active low
	input wire logic [2:0] avs_address_i, // Register word index
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [31:0] avs_writedata_i, // Write data
	input wire logic [3:0] avs_byteenable_i, // Write byte lanes
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Stall until answer
	input wire logic [7:1] irq_n_i, // VME request lines, asynchronous
	input wire logic dtack_n_i, // VME data acknowledge, asynchronous
	input wire logic berr_n_i, // VME bus error, asynchronous
	input wire logic [7:0] vme_data_i, // VME data D0-D7
	output vihb_vme_out_type vme_o, // Acknowledge-cycle strobes
	output logic bus_req_o, // Request to VME arbiter
	input wire logic bus_grant_i, // Grant from VME arbiter
	output vihb_cmd_type irq_cmd_o, // Forwarded VME interrupt command
	output vihb_cmd_type err_cmd_o, // Error interrupt command
	input wire logic ident_valid_i, // Identify command from host
	output logic vec_valid_o, // Identify response strobe
	output logic [15:0] vec_o, // Identify response vector
	input wire logic [5:0] err_event_i, // Error pulses
	input wire logic err_write_i, // Error arose in a write
	input wire logic [31:0] err_info_i // Data logged with an error
);

	if (ERR_N < 1 || ERR_N > 6)
	begin : g_bad_err_n
		$error("ERR_N must lie in 1..6");
	end

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[8*b+:8] = new_v[8*b+:8];
		return r;
	endfunction : be_merge

	// Bit 2: level sits in exactly one map field; bits 1:0: that field
	function automatic logic [2:0] map_find(input logic [11:0] m, input logic [2:0] lvl);
		logic [2:0] hits;
		logic [1:0] idx;
		hits = 3'h0;
		idx = 2'h0;
		for (int i = 0; i < 4; i++)
			if (m[3*i+:3] == lvl)
			begin
				hits = hits + 3'h1;
				idx = 2'(i);
			end
		return {hits == 3'h1, idx};
	endfunction : map_find

	function automatic logic [7:1] accept_vec(input logic [31:0] icr);
		logic [7:1] a;
		logic [2:0] f;
		a = 7'h00;
		for (int l = 1; l < 8; l++)
		begin
			f = map_find(icr[`VIHB_ICR_MAP_LSB+:12], 3'(l));
			a[l] = !icr[`VIHB_ICR_EN_LSB+l] && !icr[`VIHB_ICR_MASK_LSB-1+l] && f[2];
		end
		return a;
	endfunction : accept_vec

	function automatic logic [2:0] top_level(input logic [7:1] v);
		logic [2:0] t;
		t = 3'h0;
		for (int l = 1; l < 8; l++)
			if (v[l])
				t = 3'(l);
		return t;
	endfunction : top_level

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	vihb_state_type state_q, state_d;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] icr_q, dcr_q, vor_q, edr_q;
	logic [5:0] err_q;
	logic me_q;
	logic [7:1] pend_q, hold_q, irq_s1_q, irq_s2_q, irq_prev_q;
	logic [3:0] sent_q;
	logic dtack_s1_q, dtack_s2_q, berr_s1_q, berr_s2_q;
	logic [7:0] data_s1_q, data_s2_q, stat_q;
	logic [2:0] cur_lvl_q;
	logic [1:0] cur_br_q;
	vihb_cmd_type irq_cmd_q, err_cmd_q;
	logic vec_valid_q;
	logic [15:0] vec_q;

	// ------------------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, then the answer
	// ------------------------------------------------------------------------
	wire logic req_w = avs_read_i || avs_write_i;
	wire logic wr_w = avs_write_i && ack_q;
	wire logic [5:0] err_mask_w = 6'((7'h01 << ERR_N) - 7'h01);
	wire logic [31:0] esr_w = {11'h000, err_q, me_q, 3'h0, pend_q, sent_q};
	wire logic [31:0] rd_w = (avs_address_i == `VIHB_ESR_IDX) ? esr_w :
		(avs_address_i == `VIHB_ICR_IDX) ? icr_q :
		(avs_address_i == `VIHB_DCR_IDX) ? dcr_q :
		(avs_address_i == `VIHB_VOR_IDX) ? vor_q :
		(avs_address_i == `VIHB_EDR_IDX) ? edr_q : 32'h00000000;
	wire logic esr_wr_w = wr_w && avs_address_i == `VIHB_ESR_IDX;
	wire logic [31:0] w1c_w = esr_wr_w ? be_merge(32'h00000000, avs_writedata_i, avs_byteenable_i) : 32'h00000000;

	assign avs_waitrequest_o = req_w && !ack_q;
	assign avs_readdata_o = rdata_q;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= req_w && !ack_q;
			if (avs_read_i && !ack_q)
				rdata_q <= rd_w;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			icr_q <= `VIHB_ICR_RST;
			dcr_q <= `VIHB_DCR_RST;
			vor_q <= `VIHB_VOR_RST;
		end
		else if (wr_w)
		begin
			if (avs_address_i == `VIHB_ICR_IDX)
				icr_q <= be_merge(icr_q, avs_writedata_i, avs_byteenable_i);
			if (avs_address_i == `VIHB_DCR_IDX)
				dcr_q <= be_merge(dcr_q, avs_writedata_i, avs_byteenable_i);
			if (avs_address_i == `VIHB_VOR_IDX)
				vor_q <= be_merge(vor_q, avs_writedata_i, avs_byteenable_i) & 32'h0000ff00;
		end
	end

	// ------------------------------------------------------------------------
	// Errors: logged data stays frozen while any error bit stands
	// ------------------------------------------------------------------------
	wire logic [5:0] err_ev_w = err_event_i & err_mask_w;
	wire logic err_en_w = dcr_q[`VIHB_DCR_ERREN_BIT];

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			err_q <= 6'h00;
			me_q <= 1'b0;
			edr_q <= 32'h00000000;
			err_cmd_q <= '0;
		end
		else
		begin
			// A new event wins over a clear in the same cycle
			err_q <= (err_q & ~w1c_w[`VIHB_ESR_ERR_LSB+:6]) | err_ev_w;
			me_q <= (me_q && !w1c_w[`VIHB_ESR_ME_BIT]) || (|err_ev_w && |err_q);
			if (|err_ev_w && err_q == 6'h00)
				edr_q <= err_info_i;
			err_cmd_q.valid <= |err_ev_w && err_en_w;
			err_cmd_q.implied <= err_write_i;
			err_cmd_q.level <= dcr_q[`VIHB_DCR_LVL_LSB+:2];
		end
	end

	assign err_cmd_o = err_cmd_q;

	// ------------------------------------------------------------------------
	// Synchronisers for VME inputs
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_s1_q <= 7'h00;
			irq_s2_q <= 7'h00;
			dtack_s1_q <= 1'b0;
			dtack_s2_q <= 1'b0;
			berr_s1_q <= 1'b0;
			berr_s2_q <= 1'b0;
			data_s1_q <= 8'h00;
			data_s2_q <= 8'h00;
		end
		else
		begin
			irq_s1_q <= ~irq_n_i;
			irq_s2_q <= irq_s1_q;
			dtack_s1_q <= !dtack_n_i;
			dtack_s2_q <= dtack_s1_q;
			berr_s1_q <= !berr_n_i;
			berr_s2_q <= berr_s1_q;
			data_s1_q <= vme_data_i;
			data_s2_q <= data_s1_q;
		end
	end

	// ------------------------------------------------------------------------
	// Pending levels
	// ------------------------------------------------------------------------
	// Release-on-acknowledge levels set on the line level, release-on-register-access levels on
	// the edge only, so a line still held after its acknowledge does not raise a second request.
	wire logic [7:1] rora_w = dcr_q[`VIHB_DCR_TYPE_LSB+:7];
	wire logic [7:0] lvl_hot_w = 8'h01 << cur_lvl_q;
	wire logic ack_w = state_q == ST_IACK && (dtack_s2_q || berr_s2_q);
	wire logic [7:1] ack_clr_w = ack_w ? lvl_hot_w[7:1] : 7'h00;
	wire logic [7:1] rise_w = irq_s2_q & ~irq_prev_q;
	wire logic [7:1] set_w = rise_w | (~rora_w & irq_s2_q & ~hold_q & ~ack_clr_w);
	wire logic [7:1] cand_w = pend_q & accept_vec(icr_q);
	wire logic [2:0] top_w = top_level(cand_w);
	wire logic [2:0] map_w = map_find(icr_q[`VIHB_ICR_MAP_LSB+:12], top_w);

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_prev_q <= 7'h00;
			pend_q <= 7'h00;
			hold_q <= 7'h00;
		end
		else
		begin
			irq_prev_q <= irq_s2_q;
			pend_q <= (pend_q & ~ack_clr_w) | set_w;
			hold_q <= (hold_q | ack_clr_w) & irq_s2_q;
		end
	end

	// ------------------------------------------------------------------------
	// Service sequence
	// ------------------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
				if (|cand_w)
					state_d = ST_ARB;
			ST_ARB:
				if (bus_grant_i)
					state_d = ST_SEND;
			ST_SEND:
				state_d = ST_IDENT;
			ST_IDENT:
				if (ident_valid_i)
					state_d = ST_IACK;
			ST_IACK:
				if (dtack_s2_q || berr_s2_q)
					state_d = ST_REL;
			ST_REL:
				if (!dtack_s2_q && !berr_s2_q)
					state_d = ST_RESP;
			ST_RESP:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_q <= ST_IDLE;
			cur_lvl_q <= 3'h0;
			cur_br_q <= 2'h0;
			sent_q <= 4'h0;
			stat_q <= 8'h00;
			irq_cmd_q <= '0;
			vec_valid_q <= 1'b0;
			vec_q <= 16'h0000;
		end
		else
		begin
			state_q <= state_d;
			if (state_q == ST_IDLE && |cand_w)
			begin
				cur_lvl_q <= top_w;
				cur_br_q <= map_w[1:0];
			end
			irq_cmd_q.valid <= state_q == ST_SEND;
			irq_cmd_q.implied <= 1'b0;
			irq_cmd_q.level <= cur_br_q;
			if (state_q == ST_SEND)
				sent_q[cur_br_q] <= 1'b1;
			else if (state_q == ST_IDENT && ident_valid_i)
				sent_q <= 4'h0;
			if (ack_w)
				stat_q <= dtack_s2_q ? data_s2_q : 8'h00;
			vec_valid_q <= state_q == ST_RESP;
			vec_q <= {vor_q[`VIHB_VOR_OFS_LSB+:8], stat_q[7:2], 2'b00};
		end
	end

	// No path drives a VME request line; the handler only listens to them.
	assign bus_req_o = state_q != ST_IDLE && state_q != ST_RESP;
	assign vme_o.iack_n = state_q != ST_IACK;
	assign vme_o.as_n = state_q != ST_IACK;
	assign vme_o.ds_n = state_q != ST_IACK;
	assign vme_o.lword_n = state_q != ST_IACK;
	assign vme_o.addr = cur_lvl_q;
	assign irq_cmd_o = irq_cmd_q;
	assign vec_valid_o = vec_valid_q;
	assign vec_o = vec_q;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	a_err_cmd_raise: assert property ((|err_ev_w && err_en_w) |=> (err_cmd_o.valid
		&& err_cmd_o.implied == $past(err_write_i)))
		else $error("Enabled error did not raise its command");
	a_multi_err_flag: assert property ((|err_ev_w && |err_q) |=> me_q)
		else $error("Second error did not set the multiple-error flag");
	a_err_data_frozen: assert property ((|err_q) |=> $stable(edr_q))
		else $error("Error data changed while frozen");
	a_pend_on_rise: assert property ((|rise_w) |=> ((pend_q & $past(rise_w)) == $past(rise_w)))
		else $error("Request edge did not set its pending bit");
	a_cmd_after_grant: assert property ($rose(irq_cmd_o.valid) |-> $past(bus_grant_i, 2) && bus_req_o)
		else $error("Interrupt command issued without bus ownership");
	a_sent_bit_set: assert property (irq_cmd_o.valid |-> sent_q[irq_cmd_o.level])
		else $error("Sent bit missing for issued command");
	a_sent_cleared: assert property ((state_q == ST_IDENT && ident_valid_i) |=> sent_q == 4'h0
		##1 !vme_o.iack_n)
		else $error("Identify did not clear sent bits or start acknowledge");
	a_iack_level: assert property (!vme_o.iack_n |-> (vme_o.addr == cur_lvl_q && !vme_o.lword_n
		&& bus_req_o && cur_lvl_q != 3'h0))
		else $error("Acknowledge cycle with wrong level or width");
	a_ack_clears_pend: assert property ((ack_w && !rise_w[cur_lvl_q]) |=> !pend_q[$past(cur_lvl_q)])
		else $error("Acknowledge did not clear the pending bit");
	a_vector_form: assert property (vec_valid_o |-> (vec_o[1:0] == 2'b00
		&& vec_o[7:2] == $past(stat_q[7:2])))
		else $error("Response vector badly formed");
	a_highest_first: assert property ((state_q == ST_IDLE && |cand_w) |=> (cur_lvl_q == $past(top_w)
		&& $past({cand_w, 1'b0} >> top_w) == 8'h01))
		else $error("Lower level served before a higher one");

endmodule : vihb_core

`default_nettype wire

// *** vihb_defs.svh ***
// Register indices, field positions, reset values and timing of the VME interrupt handler bridge
`ifndef VIHB_DEFS_SVH
`define VIHB_DEFS_SVH

// ----------------------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define VIHB_ESR_IDX 3'h0
`define VIHB_ICR_IDX 3'h1
`define VIHB_DCR_IDX 3'h2
`define VIHB_VOR_IDX 3'h3
`define VIHB_EDR_IDX 3'h4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VIHB_ESR_SENT_LSB 0
`define VIHB_ESR_PEND_LSB 4
`define VIHB_ESR_ME_BIT 14
`define VIHB_ESR_ERR_LSB 15
`define VIHB_ICR_MAP_LSB 0
`define VIHB_ICR_EN_LSB 17
`define VIHB_ICR_MASK_LSB 25
`define VIHB_DCR_TYPE_LSB 0
`define VIHB_DCR_LVL_LSB 12
`define VIHB_DCR_ERREN_BIT 16
`define VIHB_VOR_OFS_LSB 8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define VIHB_ICR_RST 32'h0e000fac
`define VIHB_DCR_RST 32'h00003000
`define VIHB_VOR_RST 32'h00000000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define VIHB_SYNC_STAGES 2

`endif

// *** vihb_pkg.sv ***
// Types shared by the VME interrupt handler bridge
`default_nettype none

package vihb_pkg;

	// Handler sequence
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARB,
		ST_SEND,
		ST_IDENT,
		ST_IACK,
		ST_REL,
		ST_RESP
	} vihb_state_type;

	// Command toward the host interface; level 0..3 stands for host request level 4..7
	typedef struct packed {
		logic valid;
		logic implied;
		logic [1:0] level;
	} vihb_cmd_type;

	// Acknowledge-cycle strobes and level toward the VMEbus, all active low except addr
	typedef struct packed {
		logic iack_n;
		logic as_n;
		logic ds_n;
		logic lword_n;
		logic [2:0] addr;
	} vihb_vme_out_type;

endpackage : vihb_pkg

`default_nettype wire

// *** vihb_vme_model.sv ***
// VMEbus side partner: arbiter and D32-capable interrupters at levels 1 to 7
`default_nettype none

module vihb_vme_model
	import vihb_pkg::*;
(
	input wire logic clk_i, // Module clock
	input wire logic arst_n_i, // Asynchronous reset, active low
	input wire vihb_vme_out_type vme_i, // Acknowledge strobes from the handler
	input wire logic bus_req_i, // Bus request from the handler
	input wire logic [7:1] raise_i, // Pulse: start requests at these levels
	input wire logic [3:0] grant_dly_i, // Arbiter answer delay in cycles
	output logic [7:1] irq_n_o, // Request lines, active low
	output logic dtack_n_o, // Data acknowledge, active low
	output logic [7:0] data_o, // Status/ID on D0-D7
	output logic bus_grant_o // Grant to the handler
);
	// ----------------------------------------------------------------
	// Acknowledge decode
	// ----------------------------------------------------------------
	logic [7:1] req_q;
	logic [2:0] lvl_q;
	logic [3:0] cnt_q;
	wire logic strobes_low;
	wire logic hit;

	// Only a full 32-bit cycle at a requesting level is answered, so a wrong level or width hangs
	assign strobes_low = !vme_i.iack_n && !vme_i.as_n && !vme_i.ds_n && !vme_i.lword_n;
	assign hit = strobes_low && (vme_i.addr != 3'h0) && req_q[vme_i.addr];
	assign irq_n_o = ~req_q;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			req_q <= 7'h00;
			lvl_q <= 3'h0;
			cnt_q <= 4'h0;
			bus_grant_o <= 1'b0;
			dtack_n_o <= 1'b1;
			data_o <= 8'h00;
		end
		else
		begin
			cnt_q <= (bus_req_i && cnt_q != grant_dly_i) ? cnt_q + 4'h1 : (bus_req_i ? cnt_q : 4'h0);
			bus_grant_o <= bus_req_i && (cnt_q == grant_dly_i);
			req_q <= req_q | raise_i;
			if (hit)
			begin
				dtack_n_o <= 1'b0;
				data_o <= {vme_i.addr, 5'h17};
				lvl_q <= vme_i.addr;
			end
			else if (!dtack_n_o && !strobes_low)
			begin
				dtack_n_o <= 1'b1;
				// Released lines must not keep showing the status byte
				data_o <= ~data_o;
				req_q[lvl_q] <= 1'b0;
			end
		end
	end

endmodule : vihb_vme_model

`default_nettype wire
